// ---- verilog/itl_pkg.sv ----
// ==========================================================
// Interval timer constants
package itl_pkg;

  // ==========================================================
  // I/O port map
  localparam logic [15:0] ADDR_CNT0 = 16'h0040;
  localparam logic [15:0] ADDR_CNT1 = 16'h0041;
  localparam logic [15:0] ADDR_CNT2 = 16'h0042;
  localparam logic [15:0] ADDR_CTRL = 16'h0043;

  // ==========================================================
  // Setup word fields
  localparam int CW_SEL_HI  = 7;
  localparam int CW_SEL_LO  = 6;
  localparam int CW_RW_HI   = 5;
  localparam int CW_RW_LO   = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD     = 0;
  localparam int RB_CNT_N   = 5;
  localparam int RB_STAT_N  = 4;
  localparam int RB_SEL_LO  = 1;
  localparam int NUM_CNT    = 3;

  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH     = 2'h0;
  localparam logic [1:0] RW_LSB       = 2'h1;
  localparam logic [1:0] RW_MSB       = 2'h2;
  localparam logic [1:0] RW_WORD      = 2'h3;

  // ==========================================================
  // Reset values of the per-counter setup (undefined to software)
  localparam logic [1:0]  RW_RST   = 2'h3;
  localparam logic [2:0]  MODE_RST = 3'h0;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] CNT_TWO  = 16'h0002;
  localparam logic [3:0]  BCD_NINE = 4'h9;
  localparam logic [3:0]  BCD_ZERO = 4'h0;

  typedef enum logic [2:0] {
    MODE0 = 3'b000,
    MODE1 = 3'b001,
    MODE2 = 3'b010,
    MODE3 = 3'b011,
    MODE4 = 3'b100,
    MODE5 = 3'b101
  } itl_mode_t;

endpackage

// ---- verilog/itl_count_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// One counting element with the six counting modes
module itl_count_core (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // Count timebase and gate
  input  wire logic               tick_i,
  input  wire logic               gate_i,
  // Setup from the control side
  input  wire logic               cw_wr_i,
  input  wire itl_pkg::itl_mode_t mode_i,
  input  wire logic               bcd_i,
  input  wire logic               cr_load_i,
  input  wire logic [15:0]        cr_i,
  // State
  output logic      [15:0]        ce_o,
  output logic                    out_o,
  output logic                    null_o
);

  logic [15:0] ce_ff;
  logic [15:0] cr_ff;
  logic        out_ff;
  logic        null_ff;
  logic        pend_ff;
  logic        run_ff;
  logic        crok_ff;
  logic        gate_q_ff;
  logic        trig_ff;
  logic        at_one;
  logic        at_two;

  // Zero stands for the largest count, so it wraps to FFFF or 9999
  function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        br;
    r  = v;
    br = 1'b1;
    if (!bcd) begin
      r = v - itl_pkg::CNT_ONE;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (br) begin
          if (v[d*4 +: 4] == itl_pkg::BCD_ZERO) begin
            r[d*4 +: 4] = itl_pkg::BCD_NINE;
          end else begin
            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
            br = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  assign at_one = (ce_ff == itl_pkg::CNT_ONE);
  assign at_two = (ce_ff == itl_pkg::CNT_TWO);
  assign ce_o   = ce_ff;
  assign out_o  = out_ff;
  assign null_o = null_ff;

  // ==========================================================
  // Gate edge, held until the next count tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // Gate idles high, so a high gate after reset is no false trigger
      gate_q_ff <= 1'b1;
      trig_ff   <= 1'b0;
    end else begin
      gate_q_ff <= gate_i;
      if (gate_i && !gate_q_ff) begin
        trig_ff <= 1'b1;
      end else if (tick_i) begin
        trig_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Count register and counting element
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ce_ff   <= 16'h0000;
      cr_ff   <= 16'h0000;
      out_ff  <= 1'b0;
      null_ff <= 1'b1;
      pend_ff <= 1'b0;
      run_ff  <= 1'b0;
      crok_ff <= 1'b0;
    end else if (cw_wr_i) begin
      out_ff  <= (mode_i != itl_pkg::MODE0);
      null_ff <= 1'b1;
      pend_ff <= 1'b0;
      run_ff  <= 1'b0;
      crok_ff <= 1'b0;
    end else if (cr_load_i) begin
      // A new count is taken any time; the mode decides when it lands
      cr_ff   <= cr_i;
      pend_ff <= 1'b1;
      null_ff <= 1'b1;
      crok_ff <= 1'b1;
      if (mode_i == itl_pkg::MODE0) begin
        out_ff <= 1'b0;
      end
    end else if (tick_i) begin
      case (mode_i)
        itl_pkg::MODE0, itl_pkg::MODE4: begin
          if (pend_ff) begin
            ce_ff   <= cr_ff;
            pend_ff <= 1'b0;
            null_ff <= 1'b0;
            run_ff  <= 1'b1;
            out_ff  <= (mode_i == itl_pkg::MODE4);
          end else if (gate_i && run_ff) begin
            ce_ff <= dec1(ce_ff, bcd_i);
            if (mode_i == itl_pkg::MODE0) begin
              if (at_one) out_ff <= 1'b1;
            end else begin
              out_ff <= !at_one;
              if (at_one) run_ff <= 1'b0;
            end
          end else begin
            out_ff <= out_ff | (mode_i == itl_pkg::MODE4);
          end
        end
        itl_pkg::MODE1, itl_pkg::MODE5: begin
          if (trig_ff && crok_ff) begin
            ce_ff   <= cr_ff;
            pend_ff <= 1'b0;
            null_ff <= 1'b0;
            run_ff  <= 1'b1;
            out_ff  <= (mode_i == itl_pkg::MODE5);
          end else if (run_ff) begin
            ce_ff <= dec1(ce_ff, bcd_i);
            if (at_one) run_ff <= 1'b0;
            if (mode_i == itl_pkg::MODE1) begin
              if (at_one) out_ff <= 1'b1;
            end else begin
              out_ff <= !at_one;
            end
          end else begin
            out_ff <= out_ff | (mode_i == itl_pkg::MODE5);
          end
        end
        default: begin
          // Modes 2 and 3: periodic reload, gate low forces output high
          if ((pend_ff && !run_ff) || (trig_ff && crok_ff)) begin
            ce_ff   <= cr_ff;
            pend_ff <= 1'b0;
            null_ff <= 1'b0;
            run_ff  <= 1'b1;
            out_ff  <= 1'b1;
          end else if (!gate_i) begin
            out_ff <= 1'b1;
          end else if (run_ff) begin
            if (mode_i == itl_pkg::MODE2) begin
              if (at_one) begin
                ce_ff   <= cr_ff;
                pend_ff <= 1'b0;
                null_ff <= 1'b0;
                out_ff  <= 1'b1;
              end else begin
                ce_ff  <= dec1(ce_ff, bcd_i);
                out_ff <= !at_two;
              end
            end else if (at_one || at_two) begin
              ce_ff   <= cr_ff;
              pend_ff <= 1'b0;
              null_ff <= 1'b0;
              out_ff  <= !out_ff;
            end else begin
              ce_ff <= dec1(dec1(ce_ff, bcd_i), bcd_i);
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- verilog/itl_timer_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Top bits pick counter or read back
// - Bits 5:4 pick latch or byte order
// - Bits 3:1 pick one of six modes
// - Bit 0 picks binary or BCD counting
// - New count accepted any time after setup
// - Reset drives all timer outputs low
// - Counter ports 40h-42h, setup word 43h
// - Reachable from both ISA and PCI
// - Read back bits 3:1 select counters
// - Both latch bits low latch count and status
// - Latched count frozen until read out
// - Latched status held until port read
// - Status first, then count, then live
// - Latch command freezes selected counter count
// - Repeated latch before read is ignored
// - Second latched byte survives other accesses
// - Status byte: out, null, rw, mode, bcd
// - Counters drive timer, refresh, speaker
module itl_timer_ctrl (
  // Clock and reset (reset is the PCI-side reset)
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // ISA I/O cycles
  input  wire logic        isa_wr_i,
  input  wire logic        isa_rd_i,
  input  wire logic [15:0] isa_addr_i,
  input  wire logic [7:0]  isa_wdata_i,
  // PCI I/O cycles
  input  wire logic        pci_wr_i,
  input  wire logic        pci_rd_i,
  input  wire logic [15:0] pci_addr_i,
  input  wire logic [7:0]  pci_wdata_i,
  // Read answer
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             hit_o,
  // Counter timebase and gates
  input  wire logic        tick_i,
  input  wire logic [2:0]  gate_i,
  input  wire logic        speaker_data_en_i,
  // Timer outputs
  output logic      [2:0]  cnt_out_o,
  output logic             system_timer_interrupt_o,
  output logic             refresh_req_o,
  output logic             speaker_tone_out_o,
  output logic             port61_bit5_o
);

  localparam int N = itl_pkg::NUM_CNT;

  // ==========================================================
  // Bus merge: PCI wins a same-cycle collision
  logic        use_pci;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        hit_ctrl;
  logic [N-1:0] hit_cnt;

  assign use_pci   = pci_wr_i | pci_rd_i;
  assign bus_wr    = use_pci ? pci_wr_i : isa_wr_i;
  assign bus_rd    = use_pci ? pci_rd_i : isa_rd_i;
  assign bus_addr  = use_pci ? pci_addr_i : isa_addr_i;
  assign bus_wdata = use_pci ? pci_wdata_i : isa_wdata_i;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_cnt  = '0;
    if (bus_addr == itl_pkg::ADDR_CNT0) begin
      hit_cnt[0] = 1'b1;
    end else if (bus_addr == itl_pkg::ADDR_CNT1) begin
      hit_cnt[1] = 1'b1;
    end else if (bus_addr == itl_pkg::ADDR_CNT2) begin
      hit_cnt[2] = 1'b1;
    end else if (bus_addr == itl_pkg::ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end
  end
  assign hit_o = (|hit_cnt) | hit_ctrl;

  // ==========================================================
  // Setup word decode
  logic       cw_wr;
  logic [1:0] cw_sel;
  logic [1:0] cw_rw;
  logic       is_readback;
  logic       is_latch;
  logic       rb_cnt;
  logic       rb_stat;
  logic [N-1:0] rb_mask;

  assign cw_wr       = bus_wr & hit_ctrl;
  assign cw_sel      = bus_wdata[itl_pkg::CW_SEL_HI:itl_pkg::CW_SEL_LO];
  assign cw_rw       = bus_wdata[itl_pkg::CW_RW_HI:itl_pkg::CW_RW_LO];
  assign is_readback = (cw_sel == itl_pkg::SEL_READBACK);
  assign is_latch    = !is_readback && (cw_rw == itl_pkg::RW_LATCH);
  // Active-low latch selects; bit 0 is not looked at
  assign rb_cnt      = !bus_wdata[itl_pkg::RB_CNT_N];
  assign rb_stat     = !bus_wdata[itl_pkg::RB_STAT_N];
  assign rb_mask     = bus_wdata[itl_pkg::RB_SEL_LO +: N];

  // Mode field: x10 and x11 fold onto modes 2 and 3
  function automatic itl_pkg::itl_mode_t fold_mode(input logic [2:0] m);
    return itl_pkg::itl_mode_t'(m[1] ? {1'b0, m[1:0]} : m);
  endfunction

  // ==========================================================
  // Per-counter control, latches and read path
  logic [7:0]  rd_byte [N];
  logic [N-1:0] out_w;
  logic         rd_hit;

  assign rd_hit = bus_rd & hit_o;

  for (genvar i = 0; i < N; i++) begin : g_cnt
    logic [1:0]  rw_ff;
    logic [2:0]  mode_ff;
    logic        bcd_ff;
    logic        wr_msb_ff;
    logic        rd_msb_ff;
    logic [7:0]  lsb_ff;
    logic [15:0] ol_ff;
    logic        ol_ok_ff;
    logic [7:0]  st_ff;
    logic        st_ok_ff;
    logic        my_cw;
    logic        my_wr;
    logic        my_rd;
    logic        do_latch;
    logic        do_stat;
    logic        cr_load;
    logic [15:0] cr_val;
    logic [15:0] ce;
    logic        nul;
    logic [15:0] src;
    logic        last_byte;
    logic [7:0]  rd_sel;

    assign my_cw = cw_wr && !is_readback && !is_latch && (cw_sel == 2'(i));
    assign my_wr = bus_wr & hit_cnt[i];
    assign my_rd = bus_rd & hit_cnt[i];
    assign do_latch = cw_wr && ((is_latch && (cw_sel == 2'(i)))
                      || (is_readback && rb_mask[i] && rb_cnt));
    assign do_stat  = cw_wr && is_readback && rb_mask[i] && rb_stat;

    // Setup word fields, kept as written for the status byte
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rw_ff   <= itl_pkg::RW_RST;
        mode_ff <= itl_pkg::MODE_RST;
        bcd_ff  <= 1'b0;
      end else if (my_cw) begin
        rw_ff   <= cw_rw;
        mode_ff <= bus_wdata[itl_pkg::CW_MODE_HI:itl_pkg::CW_MODE_LO];
        bcd_ff  <= bus_wdata[itl_pkg::CW_BCD];
      end
    end

    // Count write: word access needs both bytes before loading
    always_comb begin
      cr_load = 1'b0;
      cr_val  = 16'h0000;
      if (my_wr) begin
        case (rw_ff)
          itl_pkg::RW_LSB: begin
            cr_load = 1'b1;
            cr_val  = {8'h00, bus_wdata};
          end
          itl_pkg::RW_MSB: begin
            cr_load = 1'b1;
            cr_val  = {bus_wdata, 8'h00};
          end
          default: begin
            cr_load = wr_msb_ff;
            cr_val  = {bus_wdata, lsb_ff};
          end
        endcase
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i || my_cw) begin
        wr_msb_ff <= 1'b0;
        lsb_ff    <= 8'h00;
      end else if (my_wr && (rw_ff == itl_pkg::RW_WORD)) begin
        wr_msb_ff <= !wr_msb_ff;
        lsb_ff    <= bus_wdata;
      end
    end

    // Count latch: first latch wins until fully read out
    assign last_byte = (rw_ff != itl_pkg::RW_WORD) || rd_msb_ff;
    always_ff @(posedge clk_i) begin
      if (srst_i || my_cw) begin
        ol_ff    <= 16'h0000;
        ol_ok_ff <= 1'b0;
      end else if (do_latch && !ol_ok_ff) begin
        ol_ff    <= ce;
        ol_ok_ff <= 1'b1;
      end else if (my_rd && !st_ok_ff && last_byte) begin
        ol_ok_ff <= 1'b0;
      end
    end

    // Status latch: held until the port is read
    always_ff @(posedge clk_i) begin
      if (srst_i || my_cw) begin
        st_ff    <= 8'h00;
        st_ok_ff <= 1'b0;
      end else if (do_stat && !st_ok_ff) begin
        st_ff    <= {out_w[i], nul, rw_ff, mode_ff, bcd_ff};
        st_ok_ff <= 1'b1;
      end else if (my_rd) begin
        st_ok_ff <= 1'b0;
      end
    end

    // Byte pointer survives accesses to other counters
    always_ff @(posedge clk_i) begin
      if (srst_i || my_cw) begin
        rd_msb_ff <= 1'b0;
      end else if (my_rd && !st_ok_ff && (rw_ff == itl_pkg::RW_WORD)) begin
        rd_msb_ff <= !rd_msb_ff;
      end
    end

    // Status first, then latched count, then live count
    assign src = ol_ok_ff ? ol_ff : ce;
    always_comb begin
      if (st_ok_ff) begin
        rd_sel = st_ff;
      end else if ((rw_ff == itl_pkg::RW_MSB) || ((rw_ff == itl_pkg::RW_WORD) && rd_msb_ff)) begin
        rd_sel = src[15:8];
      end else begin
        rd_sel = src[7:0];
      end
    end
    assign rd_byte[i] = rd_sel;

    itl_count_core u_core (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .tick_i    (tick_i),
      .gate_i    (gate_i[i]),
      .cw_wr_i   (my_cw),
      .mode_i    (fold_mode(mode_ff)),
      .bcd_i     (bcd_ff),
      .cr_load_i (cr_load),
      .cr_i      (cr_val),
      .ce_o      (ce),
      .out_o     (out_w[i]),
      .null_o    (nul)
    );
  end

  // ==========================================================
  // Read data register; the write-only setup word reads as zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_hit;
      if (rd_hit) begin
        if (hit_cnt[0]) begin
          rdata_o <= rd_byte[0];
        end else if (hit_cnt[1]) begin
          rdata_o <= rd_byte[1];
        end else if (hit_cnt[2]) begin
          rdata_o <= rd_byte[2];
        end else begin
          rdata_o <= 8'h00;
        end
      end
    end
  end

  // ==========================================================
  // System outputs; refresh request is one pulse per rising out1
  logic out1_q_ff;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out1_q_ff          <= 1'b0;
      refresh_req_o      <= 1'b0;
      speaker_tone_out_o <= 1'b0;
    end else begin
      out1_q_ff          <= out_w[1];
      refresh_req_o      <= out_w[1] && !out1_q_ff;
      speaker_tone_out_o <= out_w[2] && speaker_data_en_i;
    end
  end

  assign cnt_out_o                = out_w;
  assign system_timer_interrupt_o = out_w[0];
  assign port61_bit5_o            = out_w[2];

endmodule
`default_nettype wire

// ---- tb/itl_timer_ctrl_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port checks for the timer control block
module itl_timer_ctrl_asserts (
  // Watched ports
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        isa_wr_i,
  input wire logic        isa_rd_i,
  input wire logic [15:0] isa_addr_i,
  input wire logic        pci_wr_i,
  input wire logic        pci_rd_i,
  input wire logic [15:0] pci_addr_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        rvalid_o,
  input wire logic        hit_o,
  input wire logic        speaker_data_en_i,
  input wire logic [2:0]  cnt_out_o,
  input wire logic        system_timer_interrupt_o,
  input wire logic        refresh_req_o,
  input wire logic        speaker_tone_out_o,
  input wire logic        port61_bit5_o
);
  // PCI wins a cycle where both buses strobe, so the ISA read is dropped
  wire logic pci_hit = pci_addr_i[15:2] == 14'h0010;
  wire logic isa_hit = isa_addr_i[15:2] == 14'h0010;
  wire logic pci_any = pci_rd_i || pci_wr_i;
  wire logic rd_take = (pci_rd_i && pci_hit) || (isa_rd_i && isa_hit && !pci_any);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_read_answer: assert property (rd_take |=> rvalid_o)
    else $error("read hit without answer");
  a_no_stray: assert property (!rd_take |=> !rvalid_o)
    else $error("answer without a read hit");
  a_pci_decode: assert property (pci_any |-> hit_o == pci_hit)
    else $error("pci decode wrong");
  a_isa_decode: assert property ((isa_rd_i || isa_wr_i) && !pci_any |-> hit_o == isa_hit)
    else $error("isa decode wrong");
  a_reset_quiet: assert property ($fell(srst_i) |->
    {cnt_out_o, refresh_req_o, speaker_tone_out_o, port61_bit5_o,
    system_timer_interrupt_o, rvalid_o} == 8'h00)
    else $error("outputs not low after reset");
  a_irq_follows: assert property (system_timer_interrupt_o == cnt_out_o[0]
    && port61_bit5_o == cnt_out_o[2])
    else $error("timer line does not follow counter");
  a_tone_gated: assert property (!$past(srst_i) |->
    speaker_tone_out_o == $past(cnt_out_o[2] && speaker_data_en_i))
    else $error("tone not gated counter 2");
  a_refresh_rise: assert property (!$past(srst_i) && $rose(cnt_out_o[1]) |->
    ##[0:1] refresh_req_o)
    else $error("no refresh on counter 1 rise");
  a_refresh_single: assert property (refresh_req_o |=> !refresh_req_o)
    else $error("refresh wider than one cycle");
  a_rdata_hold: assert property (!$past(srst_i) && !rvalid_o |-> $stable(rdata_o))
    else $error("read data moved without a read");

  c_read: cover property (rd_take ##1 rvalid_o);
  c_refresh: cover property (refresh_req_o);
  c_tone: cover property (speaker_tone_out_o);
endmodule
`default_nettype wire

// ---- tb/itl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host side: one I/O cycle at a time on either bus
module itl_host_model (
  // Clock and read answer
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [7:0]  rdata_i,
  // I/O cycle lines
  output logic             pci_wr_o,
  output logic             pci_rd_o,
  output logic      [15:0] pci_addr_o,
  output logic      [7:0]  pci_wdata_o,
  output logic             isa_wr_o,
  output logic             isa_rd_o,
  output logic      [15:0] isa_addr_o,
  output logic      [7:0]  isa_wdata_o
);
  initial begin
    {pci_wr_o, pci_rd_o, isa_wr_o, isa_rd_o} = 4'h0;
    {pci_addr_o, isa_addr_o, pci_wdata_o, isa_wdata_o} = 48'h0;
  end

  // Released lines carry the inverse so a stale value cannot pass
  task automatic cyc(input logic isa, input logic rd, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(posedge clk_i);
    if (isa) begin
      isa_wr_o <= !rd;
      isa_rd_o <= rd;
      isa_addr_o <= a;
      isa_wdata_o <= d;
    end else begin
      pci_wr_o <= !rd;
      pci_rd_o <= rd;
      pci_addr_o <= a;
      pci_wdata_o <= d;
    end
    @(posedge clk_i);
    {pci_wr_o, pci_rd_o, isa_wr_o, isa_rd_o} <= 4'h0;
    {pci_addr_o, isa_addr_o} <= {~a, ~a};
    {pci_wdata_o, isa_wdata_o} <= {~d, ~d};
    @(posedge clk_i);
    ok = rvalid_i;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ---- tb/interval_timer_control_latch_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module interval_timer_control_latch_bench;
  logic             clk_i = 1'b0;
  logic             srst_i = 1'b1;
  logic             tick_i = 1'b0;
  logic             speaker_data_en_i = 1'b1;
  logic [2:0]       gate_i = 3'h7;
  wire logic        isa_wr_i, isa_rd_i, pci_wr_i, pci_rd_i, rvalid_o, hit_o;
  wire logic [15:0] isa_addr_i, pci_addr_i;
  wire logic [7:0]  isa_wdata_i, pci_wdata_i, rdata_o;
  wire logic [2:0]  cnt_out_o;
  wire logic        system_timer_interrupt_o, refresh_req_o, speaker_tone_out_o, port61_bit5_o;
  int               bad_count = 0;
  int               total_checks = 0;
  int               n_ref = 0;
  int               n_spk = 0;

  itl_timer_ctrl itl_timer_ctrl_i (.clk_i, .srst_i, .isa_wr_i, .isa_rd_i, .isa_addr_i,
    .isa_wdata_i, .pci_wr_i, .pci_rd_i, .pci_addr_i, .pci_wdata_i, .rdata_o, .rvalid_o,
    .hit_o, .tick_i, .gate_i, .speaker_data_en_i, .cnt_out_o, .system_timer_interrupt_o,
    .refresh_req_o, .speaker_tone_out_o, .port61_bit5_o);
  itl_host_model itl_host_model_i (.clk_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o),
    .pci_wr_o(pci_wr_i), .pci_rd_o(pci_rd_i), .pci_addr_o(pci_addr_i),
    .pci_wdata_o(pci_wdata_i), .isa_wr_o(isa_wr_i), .isa_rd_o(isa_rd_i),
    .isa_addr_o(isa_addr_i), .isa_wdata_o(isa_wdata_i));

  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_ref += (refresh_req_o === 1'b1);
    n_spk += (speaker_tone_out_o === 1'b1);
  end

  // ==========================================================
  // Shared steps
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic isa = 1'b0);
    logic [7:0] q;
    logic       ok;
    itl_host_model_i.cyc(isa, 1'b0, a, d, q, ok);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q, input logic isa = 1'b0);
    logic ok;
    itl_host_model_i.cyc(isa, 1'b1, a, 8'h00, q, ok);
    `CHK("answer", 1'b1, ok)
  endtask
  task automatic rx(input logic [15:0] a, input logic [7:0] e, input string nm,
                    input logic isa = 1'b0);
    logic [7:0] q;
    rd(a, q, isa);
    `CHK(nm, e, q)
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i) tick_i <= 1'b1;
      @(posedge clk_i) tick_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] q;
    logic       ok;
    `CHK("outs", 8'h00, {cnt_out_o, system_timer_interrupt_o, refresh_req_o, speaker_tone_out_o, port61_bit5_o, rvalid_o})
    itl_host_model_i.cyc(1'b0, 1'b1, 16'h0044, 8'h00, q, ok);
    `CHK("miss", 1'b0, ok)
    rx(16'h0043, 8'h00, "setup rd");
  endtask
  task automatic t_latch();
    logic [7:0] q;
    wr(16'h0043, 8'h34);
    wr(16'h0040, 8'h34);
    wr(16'h0040, 8'h12);
    wr(16'h0043, 8'hE2);
    rd(16'h0040, q);
    `CHK("null set", 7'h74, q[6:0])
    ticks(1);
    wr(16'h0043, 8'h00);
    ticks(1);
    wr(16'h0043, 8'h00);
    rx(16'h0040, 8'h34, "latch lo", 1'b1);
    wr(16'h0043, 8'h74, 1'b1);
    wr(16'h0041, 8'h05);
    rx(16'h0040, 8'h12, "latch hi");
    rx(16'h0040, 8'h33, "live lo");
    rx(16'h0040, 8'h12, "live hi");
  endtask
  task automatic t_readback();
    logic [7:0] q;
    wr(16'h0043, 8'hC2);
    ticks(1);
    wr(16'h0043, 8'hC2);
    rd(16'h0040, q);
    `CHK("status", 7'h34, q[6:0])
    rx(16'h0040, 8'h33, "rb lo");
    rx(16'h0040, 8'h12, "rb hi");
    rx(16'h0040, 8'h32, "after lo");
    rx(16'h0040, 8'h12, "after hi");
    wr(16'h0043, 8'hDC);
    ticks(1);
    rx(16'h0040, 8'h31, "unselected");
  endtask
  task automatic t_modes();
    logic [7:0] cw, q;
    for (int i = 0; i < 6; i++) begin
      cw = {2'b10, 2'(1 + i % 3), 3'(i), 1'(i)};
      wr(16'h0043, cw);
      wr(16'h0043, 8'hE8);
      rd(16'h0042, q);
      `CHK("mode status", cw[5:0], q[5:0])
    end
    wr(16'h0043, 8'h31);
    wr(16'h0040, 8'h10);
    wr(16'h0040, 8'h00);
    ticks(2);
    wr(16'h0043, 8'h00);
    rx(16'h0040, 8'h09, "bcd lo");
  endtask
  task automatic t_outputs();
    int r0, s0;
    wr(16'h0043, 8'h36);
    wr(16'h0040, 8'h04);
    wr(16'h0040, 8'h00);
    wr(16'h0043, 8'h74);
    wr(16'h0041, 8'h03);
    wr(16'h0041, 8'h00);
    wr(16'h0043, 8'hB6);
    wr(16'h0042, 8'h04);
    wr(16'h0042, 8'h00);
    r0 = n_ref;
    s0 = n_spk;
    ticks(30);
    `CHK("refresh", 1'b1, (n_ref - r0 >= 9 && n_ref - r0 <= 11))
    `CHK("tone", 1'b1, (n_spk > s0))
    @(posedge clk_i) speaker_data_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    s0 = n_spk;
    ticks(10);
    `CHK("tone off", s0, n_spk)
    @(posedge clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("reset outs", 8'h00, {cnt_out_o, system_timer_interrupt_o, refresh_req_o, speaker_tone_out_o, port61_bit5_o, rvalid_o})
    srst_i <= 1'b0;
  endtask

  // ==========================================================
  // Verdict
  task automatic test_done();
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #1_000_000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_latch();
    t_readback();
    t_modes();
    t_outputs();
    test_done();
  end
endmodule

bind itl_timer_ctrl itl_timer_ctrl_asserts itl_timer_ctrl_asserts_i (.clk_i, .srst_i,
  .isa_wr_i, .isa_rd_i, .isa_addr_i, .pci_wr_i, .pci_rd_i, .pci_addr_i, .rdata_o,
  .rvalid_o, .hit_o, .speaker_data_en_i, .cnt_out_o, .system_timer_interrupt_o,
  .refresh_req_o, .speaker_tone_out_o, .port61_bit5_o);
`default_nettype wire
